/* rtl/bfc_pkg.sv */
// Shared constants and carrier types for the binary function unit.
// Assumes Q16.16 signed fixed point for all normalized values and scales.
package bfc_pkg;

   localparam int          VAL_W         = 32;
   localparam int          FRAC_W        = 16;
   localparam logic [31:0] ONE_Q         = 32'h0001_0000;
   localparam logic [31:0] ZERO_Q        = 32'h0000_0000;
   localparam logic [31:0] HALF_Q        = 32'h0000_8000;
   // Smallest step of Q16.16 stands in for the tolerance of 1.0E-6.
   localparam logic [31:0] DELTA_Q       = 32'h0000_0001;
   localparam logic [31:0] SCALE_RST_Q   = 32'h0001_0000;
   localparam logic [31:0] CONST_RST_Q   = 32'h0000_0000;
   localparam logic [31:0] TEMP_MAX_Q    = 32'h0096_0000;
   localparam logic [31:0] TEMP_MIN_Q    = 32'hffce_0000;
   localparam logic [31:0] VSUP_MAX_Q    = 32'h0046_0000;
   localparam logic [31:0] VSUP_MIN_Q    = 32'h0000_0000;
   localparam logic [31:0] STATE_CODE_NA = 32'h0000_0000;

   typedef enum logic [1:0] {
      BFC_ST_VALID   = 2'h0,
      BFC_ST_SPECIAL = 2'h1,
      BFC_ST_ERROR   = 2'h2,
      BFC_ST_NA      = 2'h3
   } bfc_state_e;

   typedef enum logic [3:0] {
      BFC_OP_ADD = 4'h0,
      BFC_OP_MUL = 4'h1,
      BFC_OP_DIV = 4'h2,
      BFC_OP_MAX = 4'h3,
      BFC_OP_MIN = 4'h4,
      BFC_OP_OR  = 4'h5,
      BFC_OP_AND = 4'h6,
      BFC_OP_XOR = 4'h7,
      BFC_OP_LT  = 4'h8,
      BFC_OP_LE  = 4'h9,
      BFC_OP_EQ  = 4'ha,
      BFC_OP_GT  = 4'hb,
      BFC_OP_GE  = 4'hc
   } bfc_op_e;

   typedef struct packed {
      bfc_state_e  state;
      logic [31:0] value;
      logic [31:0] code;
   } bfc_sig_s;

endpackage

/* rtl/bfc_unit.sv */
// Binary function unit with the global constant and parameter source.
// Assumes settings are held stable by the configuring agent and that the
// temperature sample arrives already in degrees, Q16.16.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE1] Scale inputs, apply operation, scale result.
// [RULE2] Clip scaled result into zero to one.
// [RULE3] Unconnected input gives not available, zero.
// [RULE4] Per input inversion option, default off.
// [RULE5] Thirteen selectable operations, addition default.
// [RULE6] All three scales default to one.
// [RULE7] Division floors both operands at delta.
// [RULE8] Logic operations threshold operands at half.
// [RULE9] Comparisons less-equal, equal, greater-equal tolerate delta.
// [RULE10] Max, min, strict compares without tolerance.
// [RULE11] Four constants: one, zero, two programmable.
// [RULE12] Supply voltage output always not available.
// [RULE13] Temperature normalized between minus fifty, 150.
// [RULE14] Supply voltage limits seventy and zero.
// [RULE15] Invalid source forces zero, no inversion.
// [RULE16] Inverted valid input becomes one minus input.
module bfc_unit
   import bfc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        srst,
   // Setting load strobe and values.
   input  wire logic        cfg_load,
   input  wire logic        cfg_inv1,
   input  wire logic        cfg_inv2,
   input  wire logic [31:0] cfg_scale1,
   input  wire logic [31:0] cfg_scale2,
   input  wire logic [31:0] cfg_result_gain,
   input  wire logic [3:0]  cfg_op,
   input  wire logic [31:0] cfg_const1,
   input  wire logic [31:0] cfg_const2,
   // Logical inputs and their connection flags.
   input  wire logic        in1_conn,
   input  wire bfc_sig_s    in1_sig,
   input  wire logic        in2_conn,
   input  wire bfc_sig_s    in2_sig,
   input  wire logic [31:0] temp_raw,
   // Logical outputs.
   output var  bfc_sig_s    fn_out,
   output var  bfc_sig_s    const_one,
   output var  bfc_sig_s    const_zero,
   output var  bfc_sig_s    const_user1,
   output var  bfc_sig_s    const_user2,
   output var  bfc_sig_s    temp_out,
   output var  bfc_sig_s    vsup_out
);

   typedef struct packed {
      logic        inv1;
      logic        inv2;
      logic [31:0] scale1;
      logic [31:0] scale2;
      logic [31:0] gain;
      bfc_op_e     op;
      logic [31:0] c1;
      logic [31:0] c2;
   } bfc_cfg_s;

   bfc_cfg_s cfg_reg;
   bfc_cfg_s cfg_next;
   bfc_sig_s fn_reg;
   bfc_sig_s fn_next;
   bfc_sig_s temp_reg;
   bfc_sig_s temp_next;

   // Multiply two Q16.16 values, dropping the fractional excess; products
   // beyond the format saturate rather than wrap back inside the clip.
   function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
      logic signed [63:0] p;
      logic signed [31:0] r;
      p = a * b;
      r = p[47:16];
      if (p > 64'sh0000_7fff_ffff_ffff) begin
         r = 32'sh7fff_ffff;
      end else if (p < -64'sh0000_8000_0000_0000) begin
         r = 32'sh8000_0000;
      end
      return r;
   endfunction

   // Saturating sum, so large programmed scales cannot wrap past the clip.
   function automatic logic signed [31:0] qadd(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
      logic signed [32:0] s;
      logic signed [31:0] r;
      s = {a[31], a} + {b[31], b};
      r = s[31:0];
      if (s > 33'sh0_7fff_ffff) begin
         r = 32'sh7fff_ffff;
      end else if (s < -33'sh0_8000_0000) begin
         r = 32'sh8000_0000;
      end
      return r;
   endfunction

   // Signed Q16.16 divide; a tiny divisor gives a huge quotient, which
   // saturates so that the clip still yields one.
   function automatic logic signed [31:0] qdiv(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
      logic signed [63:0] n;
      logic signed [63:0] q;
      logic signed [31:0] r;
      n = {{16{a[31]}}, a, 16'h0000};
      q = n / $signed({{32{b[31]}}, b});
      r = q[31:0];
      if (q > 64'sh0000_0000_7fff_ffff) begin
         r = 32'sh7fff_ffff;
      end else if (q < -64'sh0000_0000_8000_0000) begin
         r = 32'sh8000_0000;
      end
      return r;
   endfunction

   // Input conditioning: invalid data reads as zero and is never inverted.
   function automatic logic signed [31:0] cond(input bfc_sig_s s,
                                               input logic inv);
      logic signed [31:0] v;
      v = 32'sh0000_0000;
      if (s.state == BFC_ST_VALID) begin
         v = inv ? $signed(ONE_Q) - $signed(s.value) // RULE16
                 : $signed(s.value); // RULE4
      end
      return v; // RULE15
   endfunction

   always_comb begin
      cfg_next = cfg_reg;
      if (cfg_load) begin
         cfg_next.inv1   = cfg_inv1;
         cfg_next.inv2   = cfg_inv2;
         cfg_next.scale1 = cfg_scale1;
         cfg_next.scale2 = cfg_scale2;
         cfg_next.gain   = cfg_result_gain;
         cfg_next.op     = bfc_op_e'(cfg_op);
         cfg_next.c1     = cfg_const1;
         cfg_next.c2     = cfg_const2;
      end
   end

   // One conditioning lane per input; the lanes differ only in settings.
   bfc_sig_s           lane_sig   [2];
   logic               lane_inv   [2];
   logic signed [31:0] lane_scale [2];
   logic signed [31:0] lane_x     [2];
   logic signed [31:0] lane_floor [2];
   logic               lane_bit   [2];

   assign lane_sig[0]   = in1_sig;
   assign lane_sig[1]   = in2_sig;
   assign lane_inv[0]   = cfg_reg.inv1;
   assign lane_inv[1]   = cfg_reg.inv2;
   assign lane_scale[0] = $signed(cfg_reg.scale1);
   assign lane_scale[1] = $signed(cfg_reg.scale2);

   generate
      for (genvar i = 0; i < 2; i++) begin : g_lane
         assign lane_x[i]     = qmul(cond(lane_sig[i], lane_inv[i]),
                                     lane_scale[i]); // RULE1
         assign lane_floor[i] = (lane_x[i] < $signed(DELTA_Q))
                                ? $signed(DELTA_Q) : lane_x[i]; // RULE7
         assign lane_bit[i]   = lane_x[i] >= $signed(HALF_Q); // RULE8
      end
   endgenerate

   logic signed [31:0] x;
   logic signed [31:0] y;
   logic signed [31:0] f;
   logic signed [31:0] yo;
   logic signed [31:0] dx;
   logic signed [31:0] dy;
   logic signed [31:0] dif;
   logic               bx;
   logic               by;

   always_comb begin
      x   = lane_x[0];
      y   = lane_x[1];
      dx  = lane_floor[0];
      dy  = lane_floor[1];
      bx  = lane_bit[0];
      by  = lane_bit[1];
      dif = (x >= y) ? x - y : y - x;
      case (cfg_reg.op) // RULE5
         BFC_OP_ADD: f = qadd(x, y);
         BFC_OP_MUL: f = qmul(x, y);
         BFC_OP_DIV: f = qdiv(dx, dy); // RULE7
         BFC_OP_MAX: f = (x > y) ? x : y; // RULE10
         BFC_OP_MIN: f = (x < y) ? x : y; // RULE10
         BFC_OP_OR:  f = (bx | by) ? $signed(ONE_Q) : $signed(ZERO_Q);
         BFC_OP_AND: f = (bx & by) ? $signed(ONE_Q) : $signed(ZERO_Q);
         BFC_OP_XOR: f = (bx ^ by) ? $signed(ONE_Q) : $signed(ZERO_Q);
         BFC_OP_LT:  f = (x < y) ? $signed(ONE_Q) : $signed(ZERO_Q); // RULE10
         BFC_OP_LE:  f = (x <= y + $signed(DELTA_Q)) ? $signed(ONE_Q)
                                                     : $signed(ZERO_Q); // RULE9
         BFC_OP_EQ:  f = (dif <= $signed(DELTA_Q)) ? $signed(ONE_Q)
                                                   : $signed(ZERO_Q); // RULE9
         BFC_OP_GT:  f = (x > y) ? $signed(ONE_Q) : $signed(ZERO_Q); // RULE10
         BFC_OP_GE:  f = (x >= y - $signed(DELTA_Q)) ? $signed(ONE_Q)
                                                     : $signed(ZERO_Q); // RULE9
         default:    f = $signed(ZERO_Q);
      endcase
      yo = qmul(f, $signed(cfg_reg.gain)); // RULE1
      fn_next.state = BFC_ST_VALID;
      fn_next.code  = STATE_CODE_NA;
      if (yo < $signed(ZERO_Q)) begin
         fn_next.value = ZERO_Q; // RULE2
      end else if (yo > $signed(ONE_Q)) begin
         fn_next.value = ONE_Q; // RULE2
      end else begin
         fn_next.value = yo; // RULE2
      end
      if (!in1_conn || !in2_conn) begin
         fn_next.state = BFC_ST_NA; // RULE3
         fn_next.value = ZERO_Q; // RULE3
      end
   end

   // Temperature normalization; the divide is costly and is its own qdiv, apart from the one for the division operation.
   logic signed [31:0] tn;
   always_comb begin
      tn = qdiv($signed(temp_raw) - $signed(TEMP_MIN_Q),
                $signed(TEMP_MAX_Q) - $signed(TEMP_MIN_Q)); // RULE13
      temp_next.state = BFC_ST_VALID;
      temp_next.code  = STATE_CODE_NA;
      if (tn < $signed(ZERO_Q)) begin
         temp_next.value = ZERO_Q;
      end else if (tn > $signed(ONE_Q)) begin
         temp_next.value = ONE_Q;
      end else begin
         temp_next.value = tn;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_reg.inv1   <= 1'b0; // RULE4
         cfg_reg.inv2   <= 1'b0; // RULE4
         cfg_reg.scale1 <= SCALE_RST_Q; // RULE6
         cfg_reg.scale2 <= SCALE_RST_Q; // RULE6
         cfg_reg.gain   <= SCALE_RST_Q; // RULE6
         cfg_reg.op     <= BFC_OP_ADD; // RULE5
         cfg_reg.c1     <= CONST_RST_Q; // RULE11
         cfg_reg.c2     <= CONST_RST_Q; // RULE11
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fn_reg   <= '{BFC_ST_NA, ZERO_Q, STATE_CODE_NA};
         temp_reg <= '{BFC_ST_NA, ZERO_Q, STATE_CODE_NA};
      end else begin
         fn_reg   <= fn_next;
         temp_reg <= temp_next;
      end
   end

   // Even the fixed outputs leave a flop, so every port is a register.
   // The user constants follow the load strobe in the same cycle as the
   // setting registers, so they show no extra latency.
   bfc_sig_s one_reg;
   bfc_sig_s one_next;
   bfc_sig_s zero_reg;
   bfc_sig_s zero_next;
   bfc_sig_s user1_reg;
   bfc_sig_s user1_next;
   bfc_sig_s user2_reg;
   bfc_sig_s user2_next;
   bfc_sig_s vsup_reg;
   bfc_sig_s vsup_next;

   always_comb begin
      one_next   = '{BFC_ST_VALID, ONE_Q, STATE_CODE_NA}; // RULE11
      zero_next  = '{BFC_ST_VALID, ZERO_Q, STATE_CODE_NA}; // RULE11
      user1_next = '{BFC_ST_VALID, cfg_next.c1, STATE_CODE_NA}; // RULE11
      user2_next = '{BFC_ST_VALID, cfg_next.c2, STATE_CODE_NA}; // RULE11
      // The sensing circuit is absent, so limits are kept but unused.
      vsup_next  = '{BFC_ST_NA, VSUP_MIN_Q & VSUP_MAX_Q & ZERO_Q,
                     STATE_CODE_NA}; // RULE12 RULE14
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         one_reg   <= '{BFC_ST_VALID, ONE_Q, STATE_CODE_NA};
         zero_reg  <= '{BFC_ST_VALID, ZERO_Q, STATE_CODE_NA};
         user1_reg <= '{BFC_ST_VALID, CONST_RST_Q, STATE_CODE_NA};
         user2_reg <= '{BFC_ST_VALID, CONST_RST_Q, STATE_CODE_NA};
         vsup_reg  <= '{BFC_ST_NA, ZERO_Q, STATE_CODE_NA};
      end else begin
         one_reg   <= one_next;
         zero_reg  <= zero_next;
         user1_reg <= user1_next;
         user2_reg <= user2_next;
         vsup_reg  <= vsup_next;
      end
   end

   assign fn_out      = fn_reg;
   assign temp_out    = temp_reg;
   assign const_one   = one_reg;
   assign const_zero  = zero_reg;
   assign const_user1 = user1_reg;
   assign const_user2 = user2_reg;
   assign vsup_out    = vsup_reg;

endmodule

`default_nettype wire

/* bench/bfc_unit_sva.sv */
// Concurrent checks on the ports of the binary function unit.
// Assumes bfc_pkg is compiled first; bound into every bfc_unit.
`timescale 1ns/1ps
`default_nettype none
module bfc_unit_sva
   import bfc_pkg::*;
(
   // Clock, reset and stimulus.
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        cfg_load,
   input wire logic [31:0] cfg_const1,
   input wire logic        in1_conn,
   input wire logic        in2_conn,
   input wire logic [31:0] temp_raw,
   // Outputs under watch.
   input wire bfc_sig_s    fn_out,
   input wire bfc_sig_s    const_one,
   input wire bfc_sig_s    const_zero,
   input wire bfc_sig_s    const_user1,
   input wire bfc_sig_s    temp_out,
   input wire bfc_sig_s    vsup_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   vsup_na_a: assert property (vsup_out.state == BFC_ST_NA)
      else $error("supply output available");
   const_one_a: assert property (const_one.value == ONE_Q)
      else $error("one constant wrong");
   const_zero_a: assert property (const_zero.value == ZERO_Q)
      else $error("zero constant wrong");
   unconn_na_a: assert property (!(in1_conn && in2_conn) |=>
      fn_out.state == BFC_ST_NA && fn_out.value == ZERO_Q)
      else $error("unconnected result wrong");
   clip_range_a: assert property (fn_out.value <= ONE_Q)
      else $error("result outside zero to one");
   temp_max_a: assert property (temp_raw == TEMP_MAX_Q |=>
      temp_out.value == ONE_Q) else $error("hot limit wrong");
   temp_min_a: assert property (temp_raw == TEMP_MIN_Q |=>
      temp_out.value == ZERO_Q) else $error("cold limit wrong");
   user_const_a: assert property (cfg_load |=>
      const_user1.value == $past(cfg_const1)) else $error("constant lost");
   cover property (!in1_conn);
   cover property (cfg_load);
   cover property (temp_raw == TEMP_MAX_Q);
endmodule
bind bfc_unit bfc_unit_sva u_sva (.*);
`default_nettype wire

/* bench/bfc_src.sv */
// Model of an upstream function block feeding one logical input.
// Assumes the bench picks the state and the normalized value.
`timescale 1ns/1ps
`default_nettype none
module bfc_src
   import bfc_pkg::*;
(
   // Requested source state and value.
   input  wire logic [1:0]  st,
   input  wire logic [31:0] v,
   // Logical signal toward the unit.
   output var  bfc_sig_s    sig
);
   // A source without valid data never shows a value; only special and error sources show a state code.
   always_comb begin
      sig.state = bfc_state_e'(st);
      sig.value = (st == BFC_ST_VALID) ? v : ZERO_Q;
      sig.code  = (st[1] ^ st[0]) ? 32'hffff_ffff : STATE_CODE_NA;
   end
endmodule
`default_nettype wire

/* bench/bfc_unit_tb.sv */
// Self-checking bench for the binary function unit.
// Assumes the checker is bound and two bfc_src models feed the inputs.
`timescale 1ns/1ps
`default_nettype none
module bfc_unit_tb
   import bfc_pkg::*;
;
   logic        clk = 0, srst = 1, cfg_load = 0, cfg_inv1 = 0, cfg_inv2 = 0;
   logic [31:0] cfg_scale1 = ONE_Q, cfg_scale2 = ONE_Q, cfg_result_gain;
   logic [31:0] cfg_const1 = 0, cfg_const2 = 0, temp_raw = 0, v1, v2;
   logic [3:0]  cfg_op = 0;
   logic [1:0]  st1 = 0, st2 = 0;
   logic        in1_conn = 1, in2_conn = 1;
   logic [19:0] e;
   bfc_sig_s    in1_sig, in2_sig, fn_out, const_one, const_zero;
   bfc_sig_s    const_user1, const_user2, temp_out, vsup_out;
   int          err_total = 0, total_checks = 0;
   logic [31:0] temps [3] = '{TEMP_MIN_Q, 32'h0032_0000, TEMP_MAX_Q};
   // Row: mode {gain -1, half scales, inv2, inv1, op}, x, y, result.
   logic [67:0] rows [25] = '{
      68'h00_04000_08000_0c000, 68'h00_0c000_08000_10000,
      68'h40_08000_08000_08000, 68'h80_08000_08000_00000,
      68'h10_04000_00000_0c000, 68'h20_00000_04000_0c000,
      68'h01_08000_08000_04000, 68'h02_04000_08000_08000,
      68'h02_00000_00000_10000, 68'h03_04000_08000_08000,
      68'h04_04000_08000_04000, 68'h05_08000_00000_10000,
      68'h06_08000_07fff_00000, 68'h07_08000_08000_00000,
      68'h08_08000_08000_00000, 68'h09_08001_08000_10000,
      68'h0a_08001_08000_10000, 68'h0b_08000_04000_10000,
      68'h0c_07fff_08000_10000, 68'h02_08000_04000_10000,
      68'h02_08000_00000_10000, 68'h09_08002_08000_00000,
      68'h0a_08002_08000_00000, 68'h0c_07ffe_08000_00000,
      68'h0b_08000_08000_00000};
   always #2.5 clk = ~clk;
   bfc_src P1 (.st(st1), .v(v1), .sig(in1_sig));
   bfc_src P2 (.st(st2), .v(v2), .sig(in2_sig));
   bfc_unit DUT (.*);
   task step;
      @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task cfg(input logic [7:0] m);
      cfg_op = m[3:0];
      cfg_inv1 = m[4];
      cfg_inv2 = m[5];
      cfg_scale1 = m[6] ? 32'h8000 : ONE_Q;
      cfg_scale2 = cfg_scale1;
      cfg_result_gain = m[7] ? 32'hffff_0000 : ONE_Q;
      cfg_load = 1;
      step;
      cfg_load = 0;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      cfg_result_gain = ONE_Q;
      v1 = 0;
      v2 = 0;
      repeat (3) step;
      srst = 0;
      foreach (rows[i]) begin
         cfg(rows[i][67:60]);
         v1 = {12'h0, rows[i][59:40]};
         v2 = {12'h0, rows[i][39:20]};
         e = rows[i][19:0];
         repeat (2) step;
         chk(32'(fn_out.state), 32'(BFC_ST_VALID));
         chk(fn_out.value, {12'h0, e});
      end
      $display("operation table done");
      cfg(8'hd0);
      srst = 1;
      step;
      srst = 0;
      v1 = 32'h4000;
      v2 = 32'h8000;
      repeat (2) step;
      chk(fn_out.value, 32'hc000);
      $display("reset defaults done");
      for (int i = 0; i < 2; i++) begin
         in1_conn = i[0];
         in2_conn = !i[0];
         repeat (2) step;
         chk(32'(fn_out.state), 32'(BFC_ST_NA));
         chk(fn_out.value, ZERO_Q);
      end
      in1_conn = 1;
      in2_conn = 1;
      $display("unconnected done");
      cfg_const1 = 32'h8000;
      cfg_const2 = ONE_Q;
      st1 = BFC_ST_ERROR;
      v2 = 32'h4000;
      cfg(8'h10);
      repeat (2) step;
      chk(fn_out.value, 32'h4000);
      chk(const_user1.value, 32'h8000);
      chk(const_user2.value, ONE_Q);
      chk(32'(vsup_out.state), 32'(BFC_ST_NA));
      $display("invalid source and constants done");
      for (int i = 0; i < 3; i++) begin
         temp_raw = temps[i];
         repeat (2) step;
         chk(temp_out.value, 32'(i) << 15);
      end
      $display("temperature done");
      give_verdict;
   end
   // Limit is far above the roughly 95 cycles the tests need.
   initial begin
      #5000;
      err_total++;
      give_verdict;
   end
endmodule
`default_nettype wire
